// >>> coprocessor_host_handshake_clocking_tb_top.sv
// Self-checking bench: host and coprocessor ends joined by the pin interface.
// Assumes the ends in cpx_pkg, cpx_bus_if, cpx_device and cpx_host.
`timescale 1ns/10ps
`default_nettype none
module coprocessor_host_handshake_clocking_tb_top;
    import cpx_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [31:0] wr_data = 32'h0, rd_data, acc = 32'h0;
    logic cmd_taken, wr_taken, rd_valid, link_up, sync_mode, op_done;
    logic [4:0] e;
    logic [4:0] exp_q[$];
    logic [31:0] rd_q[$];
    int miscompares = 0, check_count = 0, cycles = 0;
    cpx_bus_if cpx_bus_if_i ();
    cpx_device cpx_device_i (.i_mclk(i_mclk), .i_rst(i_rst), .bus(cpx_bus_if_i), .o_sync_mode(sync_mode),
        .o_op_done(op_done));
    cpx_host cpx_host_i (.i_mclk(i_mclk), .i_rst(i_rst), .bus(cpx_bus_if_i), .i_cmd_valid(cmd_valid),
        .i_cmd_op(cmd_op), .o_cmd_taken(cmd_taken), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
        .o_wr_taken(wr_taken), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_link_up(link_up));
    cpx_link_monitor cpx_link_monitor_i (.i_mclk(i_mclk), .i_rst(i_rst), .status_enable(cpx_bus_if_i.status_enable),
        .select_one_n(cpx_bus_if_i.select_one_n), .select_two(cpx_bus_if_i.select_two),
        .write_read(cpx_bus_if_i.write_read), .address_strobe_n(cpx_bus_if_i.address_strobe_n),
        .system_reset_in(cpx_bus_if_i.system_reset_in), .dev_data_oe(cpx_bus_if_i.dev_data_oe),
        .dev_ctl_oe(cpx_bus_if_i.dev_ctl_oe), .cycle_done_n_out(cpx_bus_if_i.cycle_done_n_out),
        .busy_n_out(cpx_bus_if_i.busy_n_out), .transfer_request_out(cpx_bus_if_i.transfer_request_out),
        .error_n_out(cpx_bus_if_i.error_n_out));
    initial forever #12.5 i_mclk = ~i_mclk;
    // Core clock unrelated to the host's, within the allowed ratio.
    initial begin
        cpx_bus_if_i.core_double_clock = 1'b0;
        forever #15 cpx_bus_if_i.core_double_clock = ~cpx_bus_if_i.core_double_clock;
    end
    task automatic tick;
        @(posedge i_mclk);
        #1;
    endtask : tick
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic run_op(input logic [3:0] op, input logic [3:0] cnt, input logic err);
        exp_q.push_back({(op == OP_STORE) ? cnt : 4'h0, err});
        tick();
        cmd_op = {cnt, op};
        cmd_valid = 1'b1;
        do tick(); while (cmd_taken !== 1'b1);
        cmd_valid = 1'b0;
        if (op == OP_LOAD) acc = 32'h0;
        if (op == OP_LOAD) repeat (cnt) begin
            tick();
            wr_data = $urandom;
            acc ^= wr_data;
            wr_valid = 1'b1;
            do tick(); while (wr_taken !== 1'b1);
            wr_valid = 1'b0;
        end
    endtask : run_op
    always @(negedge i_mclk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    initial forever begin
        @(negedge i_mclk);
        if (op_done === 1'b1) begin
            e = exp_q.pop_front();
            repeat (6) @(negedge i_mclk);
            check("error_n", 32'(cpx_bus_if_i.error_n), 32'(e[0]));
            check("read_words", rd_q.size(), 32'(e[4:1]));
            foreach (rd_q[i]) check("read_data", rd_q[i], acc + 32'(i));
            rd_q = {};
        end
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h57fc2bb0));
        for (int m = 1; m >= 0; m--) begin
            cpx_bus_if_i.clocking_mode_strap = m[0];
            i_rst = 1'b1;
            repeat (12) tick();
            i_rst = 1'b0;
            do tick(); while (link_up !== 1'b1);
            check("sync_mode", 32'(sync_mode), 32'(m[0]));
            check("error_after_reset", 32'(cpx_bus_if_i.error_n), 32'h0);
            run_op(OP_CLEAR, 4'h0, 1'b1);
            run_op(OP_LOAD, 4'h1 + 4'($urandom_range(3)), 1'b1);
            run_op(OP_STORE, 4'h1 + 4'($urandom_range(3)), 1'b1);
            run_op(OP_FAULT, 4'h0, 1'b0);
            run_op(OP_NOP, 4'h0, 1'b0);
            run_op(OP_CLEAR, 4'h0, 1'b1);
            repeat (40) tick();
        end
        give_verdict();
    end
endmodule : coprocessor_host_handshake_clocking_tb_top
`default_nettype wire

// >>> cpx_bus_if.sv
// Pin-level link between the coprocessor and its host.
// Assumes the testbench drives the core clock pin and the clocking strap.
`timescale 1ns/10ps
`default_nettype none
interface cpx_bus_if;
    logic status_enable, select_one_n, select_two, command_select_n, write_read;
    logic address_strobe_n, bus_ready_n, system_reset_in;
    logic core_double_clock, clocking_mode_strap;
    logic [31:0] host_data_out, dev_data_out, data_bus;
    logic host_data_oe, dev_data_oe, dev_ctl_oe;
    logic cycle_done_n_out, busy_n_out, transfer_request_out, error_n_out;
    logic cycle_done_n, busy_n, transfer_request, error_n;
    // Floating outputs read as their pulled idle level.
    assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 32'h0);
    assign cycle_done_n = dev_ctl_oe ? cycle_done_n_out : 1'b1;
    assign busy_n = dev_ctl_oe ? busy_n_out : 1'b1;
    assign error_n = dev_ctl_oe ? error_n_out : 1'b1;
    assign transfer_request = dev_ctl_oe ? transfer_request_out : 1'b0;
    assign bus_ready_n = cycle_done_n;
    modport device(input status_enable, select_one_n, select_two, command_select_n, write_read,
        address_strobe_n, bus_ready_n, system_reset_in, core_double_clock, clocking_mode_strap, data_bus,
        output dev_data_out, dev_data_oe, dev_ctl_oe, cycle_done_n_out, busy_n_out, transfer_request_out,
        error_n_out);
    modport host(output status_enable, select_one_n, select_two, command_select_n, write_read,
        address_strobe_n, system_reset_in, host_data_out, host_data_oe,
        input data_bus, cycle_done_n, busy_n, transfer_request, error_n);
endinterface : cpx_bus_if
`default_nettype wire

// >>> cpx_device.sv
// Coprocessor end: bus tracking, operand FIFO handshake and core sequencing.
// Assumes one 40 MHz host double clock; the core clock pin is only sampled.
//
// How it works
// RL1: Control outputs float unless status enable asserted.
// RL2: Data driven only on selected read cycles.
// RL3: Hash names active low, others active high.
// RL4: Bus logic divides host double clock by two.
// RL5: Strap high: core runs on host clock.
// RL6: Strap low: core clock ratio 10:16..14:10.
// RL7: Strap sets core clocking only, bus stays synchronous.
// RL8: Reset rise abandons activity, device goes dormant.
// RL9: Host holds reset 40 core periods.
// RL10: Reset falls synchronous with host double clock.
// RL11: Host waits 50 core periods before instructions.
// RL12: Reset: ready, busy high; request, error low. Control pins float in reset here, so error reads high.
// RL13: Request while FIFO awaits transfer, drops when done.
// RL14: Request drops before busy drops.
// RL15: Busy asserted low while executing.
// RL16: Error follows summary bit, cleared by clear opcode.
// RL17: Selected only if all selects active at first period.
// RL18: Writes end after two clocks, reads three.
// RL19: Core-side signals synchronised before use.
`timescale 1ns/10ps
`default_nettype none
module cpx_device (
    input wire logic i_mclk, // Host double clock.
    input wire logic i_rst, // Synchronous reset, active high.
    cpx_bus_if.device bus, // Pins toward the host.
    output logic o_sync_mode, // Captured clocking strap.
    output logic o_op_done // Pulse when an instruction completes.
);
    import cpx_pkg::*;

    logic [9:0] pin_s1_q, pin_s2_q;
    logic [31:0] dat_s1_q, dat_s2_q;
    logic rst_s, status_enable_s, sel1n_s, sel2_s, cmdn_s, wr_s, adsn_s, rdyn_s, ck_s, strap_s;
    logic rst, phase_q, clk_en, mode_q, ck_prev_q, core_tick, sel_s;
    cpx_bus_state_type bst_q;
    logic [1:0] bcnt_q, btarget;
    logic bwr_q, bcmd_q, fin, cmd_start;
    logic done_n_q, data_oe_q, ctl_oe_q;
    logic [31:0] rd_data_q, status;
    cpx_core_state_type cst_q;
    logic [3:0] op_q, cnt_q, idx_q;
    logic [7:0] timer_q;
    logic [31:0] acc_q;
    logic busy_n_q, req_q, err_n_q, op_done_q;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [31:0] f_in_data, f_out_data;

    // Pins, core clock included, pass two flops.
    always_ff @(posedge i_mclk) begin
        pin_s1_q <= {bus.system_reset_in, bus.status_enable, bus.select_one_n, bus.select_two,
                     bus.command_select_n, bus.write_read, bus.address_strobe_n, bus.bus_ready_n,
                     bus.core_double_clock, bus.clocking_mode_strap};
        pin_s2_q <= pin_s1_q;
        dat_s1_q <= bus.data_bus;
        dat_s2_q <= dat_s1_q;
    end
    assign {rst_s, status_enable_s, sel1n_s, sel2_s, cmdn_s, wr_s, adsn_s, rdyn_s, ck_s, strap_s} = pin_s2_q;

    assign rst = i_rst | rst_s; // RL8

    // Phase restarts with reset to line up with the host's.
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q; // RL4
        end
    end
    assign clk_en = phase_q;

    // Strap caught during reset, frozen after.
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            mode_q <= strap_s; // RL7
        end
    end

    always_ff @(posedge i_mclk) begin
        if (rst) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s; // RL19
        end
    end
    // Async mode: core steps on synced core clock rises.
    assign core_tick = mode_q | (ck_s & ~ck_prev_q); // RL5 RL6

    assign sel_s = status_enable_s & ~sel1n_s & sel2_s; // RL17
    assign btarget = bwr_q ? (WR_CLKS - 2'h1) : (RD_CLKS - 2'h1); // RL18
    // A write into a full FIFO holds the cycle open, stalling the host.
    assign fin = clk_en & (bst_q == B_ACT) & (bcnt_q == btarget) & ~(bwr_q & ~bcmd_q & ~f_in_ready);
    assign cmd_start = fin & bwr_q & bcmd_q;

    always_ff @(posedge i_mclk) begin
        if (rst) begin
            bst_q <= B_IDLE;
            bcnt_q <= 2'h0;
            bwr_q <= 1'b0;
            bcmd_q <= 1'b0;
            done_n_q <= 1'b1; // RL12
        end else if (clk_en) begin
            case (bst_q)
                B_IDLE: begin
                    if (~adsn_s && sel_s) begin
                        bst_q <= B_ACT;
                        bcnt_q <= 2'h1;
                        bwr_q <= wr_s;
                        bcmd_q <= ~cmdn_s;
                    end else if (~adsn_s) begin
                        bst_q <= B_FOREIGN;
                    end
                end
                B_FOREIGN: begin
                    if (~rdyn_s) begin
                        bst_q <= B_IDLE;
                    end
                end
                B_ACT: begin
                    if (fin) begin
                        bst_q <= B_DONE;
                        done_n_q <= 1'b0; // RL18
                    end else if (bcnt_q != btarget) begin
                        bcnt_q <= bcnt_q + 2'h1;
                    end
                end
                B_DONE: begin
                    bst_q <= B_IDLE;
                    done_n_q <= 1'b1;
                end
                default: bst_q <= B_IDLE;
            endcase
        end
    end

    assign status = {28'h0, mode_q, req_q, ~busy_n_q, ~err_n_q};
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            rd_data_q <= 32'h0;
            data_oe_q <= 1'b0; // RL12
            ctl_oe_q <= 1'b0;
        end else begin
            if (bst_q == B_ACT) begin
                rd_data_q <= bcmd_q ? status : f_out_data;
            end
            data_oe_q <= status_enable_s & ~bwr_q & ((bst_q == B_ACT) | (bst_q == B_DONE)); // RL2
            ctl_oe_q <= status_enable_s; // RL1
        end
    end

    // Shared FIFO: host fills it for loads, core for stores.
    assign f_in_valid = (cst_q == C_STORE) ? core_tick : (fin & bwr_q & ~bcmd_q);
    assign f_in_data = (cst_q == C_STORE) ? (acc_q + 32'(idx_q)) : dat_s2_q;
    assign f_out_ready = (cst_q == C_LOAD) ? core_tick : (fin & ~bwr_q & ~bcmd_q);

    cpx_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(rst),
        .i_in_valid(f_in_valid),
        .o_in_ready(f_in_ready),
        .i_in_data(f_in_data),
        .o_out_valid(f_out_valid),
        .i_out_ready(f_out_ready),
        .o_out_data(f_out_data)
    );

    always_ff @(posedge i_mclk) begin
        if (rst) begin
            cst_q <= C_IDLE;
            op_q <= OP_NOP;
            cnt_q <= 4'h0;
            idx_q <= 4'h0;
            timer_q <= 8'h0;
            acc_q <= 32'h0;
            busy_n_q <= 1'b1; // RL12
            req_q <= 1'b0;
            op_done_q <= 1'b0;
        end else begin
            op_done_q <= 1'b0;
            case (cst_q)
                C_IDLE: begin
                    if (cmd_start) begin
                        op_q <= dat_s2_q[OP_POS +: 4];
                        cnt_q <= dat_s2_q[CNT_POS +: 4];
                        idx_q <= 4'h0;
                        timer_q <= EXEC_TICKS;
                        busy_n_q <= 1'b0; // RL15
                        if (dat_s2_q[OP_POS +: 4] == OP_LOAD && dat_s2_q[CNT_POS +: 4] != 4'h0) begin
                            acc_q <= 32'h0;
                            req_q <= 1'b1; // RL13
                            cst_q <= C_LOAD;
                        end else begin
                            cst_q <= C_EXEC;
                        end
                    end
                end
                C_LOAD: begin
                    if (core_tick && f_out_valid) begin
                        acc_q <= acc_q ^ f_out_data;
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == cnt_q - 4'h1) begin
                            req_q <= 1'b0; // RL13
                            idx_q <= 4'h0;
                            cst_q <= C_EXEC;
                        end
                    end
                end
                C_EXEC: begin
                    if (core_tick) begin
                        timer_q <= timer_q - 8'h1;
                        if (timer_q == 8'h1) begin
                            cst_q <= (op_q == OP_STORE && cnt_q != 4'h0) ? C_STORE : C_END;
                        end
                    end
                end
                C_STORE: begin
                    if (core_tick && f_in_ready) begin
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == cnt_q - 4'h1) begin
                            req_q <= 1'b1; // RL13
                            cst_q <= C_DRAIN;
                        end
                    end
                end
                C_DRAIN: begin
                    if (~f_out_valid) begin
                        req_q <= 1'b0; // RL13
                        cst_q <= C_END;
                    end
                end
                C_END: begin
                    // Busy drops at least one cycle after the request.
                    busy_n_q <= 1'b1; // RL14
                    op_done_q <= 1'b1;
                    cst_q <= C_IDLE;
                end
                default: cst_q <= C_IDLE;
            endcase
        end
    end

    // Error is asserted out of reset; only the clear opcode lowers it.
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            err_n_q <= 1'b0; // RL12
        end else if (cst_q == C_EXEC && core_tick && timer_q == 8'h1 && op_q == OP_FAULT) begin
            err_n_q <= 1'b0; // RL16
        end else if (cmd_start && cst_q == C_IDLE && dat_s2_q[OP_POS +: 4] == OP_CLEAR) begin
            err_n_q <= 1'b1; // RL16
        end
    end

    assign bus.dev_data_out = rd_data_q;
    assign bus.dev_data_oe = data_oe_q;
    assign bus.dev_ctl_oe = ctl_oe_q;
    assign bus.cycle_done_n_out = done_n_q;
    assign bus.busy_n_out = busy_n_q;
    assign bus.transfer_request_out = req_q;
    assign bus.error_n_out = err_n_q; // RL3
    assign o_sync_mode = mode_q;
    assign o_op_done = op_done_q;
endmodule : cpx_device
`default_nettype wire

// >>> cpx_fifo.sv
// Operand FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/10ps
`default_nettype none
module cpx_fifo #(parameter int W = 32, parameter int DEPTH = 16) (
    input wire logic i_mclk, // Clock.
    input wire logic i_rst, // Synchronous reset.
    input wire logic i_in_valid, // Write request.
    output logic o_in_ready, // Space available.
    input wire logic [W-1:0] i_in_data, // Write word.
    output logic o_out_valid, // Word available.
    input wire logic i_out_ready, // Read request.
    output logic [W-1:0] o_out_data // Head word.
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;
    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rp_q];
    assign push = i_in_valid & o_in_ready;
    assign pop = i_out_ready & o_out_valid;
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wp_q] <= i_in_data;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= rp_q + AW'(1);
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end
endmodule : cpx_fifo
`default_nettype wire

// >>> cpx_host.sv
// Host end: drives reset, instruction writes and operand transfers over the pins.
// Assumes it shares the 40 MHz host double clock with the coprocessor.
`timescale 1ns/10ps
`default_nettype none
module cpx_host (
    input wire logic i_mclk, // Host double clock.
    input wire logic i_rst, // Synchronous reset, active high.
    cpx_bus_if.host bus, // Pins toward the coprocessor.
    input wire logic i_cmd_valid, // Instruction offered.
    input wire logic [7:0] i_cmd_op, // Instruction word.
    output logic o_cmd_taken, // Pulse: instruction accepted.
    input wire logic i_wr_valid, // Operand offered.
    input wire logic [31:0] i_wr_data, // Operand word.
    output logic o_wr_taken, // Pulse: operand accepted.
    output logic o_rd_valid, // Pulse: result word valid.
    output logic [31:0] o_rd_data, // Result word.
    output logic o_link_up // Reset wait finished.
);
    import cpx_pkg::*;

    logic [2:0] in_s1_q, in_s2_q;
    logic [31:0] dat_s1_q, dat_s2_q;
    logic done_n_s, busy_n_s, req_s;
    cpx_host_state_type hst_q;
    logic [7:0] tmr_q;
    logic [3:0] rem_q;
    logic dir_load_q, phase_q;
    logic sreset_q, adsn_q, sel1n_q, sel2_q, cmdn_q, wr_q, hoe_q;
    logic [31:0] hdata_q;
    logic cmd_taken_q, wr_taken_q, rd_valid_q, link_up_q;
    logic [31:0] rd_data_q;

    always_ff @(posedge i_mclk) begin
        in_s1_q <= {bus.cycle_done_n, bus.busy_n, bus.transfer_request};
        in_s2_q <= in_s1_q;
        dat_s1_q <= bus.data_bus;
        dat_s2_q <= dat_s1_q;
    end
    assign {done_n_s, busy_n_s, req_s} = in_s2_q;

    always_ff @(posedge i_mclk) begin
        if (i_rst || hst_q == H_RST) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            hst_q <= H_RST;
            tmr_q <= 8'h0;
            rem_q <= 4'h0;
            dir_load_q <= 1'b0;
            sreset_q <= 1'b1;
            adsn_q <= 1'b1;
            sel1n_q <= 1'b1;
            sel2_q <= 1'b0;
            cmdn_q <= 1'b1;
            wr_q <= 1'b0;
            hoe_q <= 1'b0;
            hdata_q <= 32'h0;
            cmd_taken_q <= 1'b0;
            wr_taken_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q <= 32'h0;
            link_up_q <= 1'b0;
        end else begin
            cmd_taken_q <= 1'b0;
            wr_taken_q <= 1'b0;
            rd_valid_q <= 1'b0;
            case (hst_q)
                H_RST: begin
                    tmr_q <= tmr_q + 8'h1;
                    if (tmr_q == 8'(RST_HOLD_CYC - 1)) begin
                        sreset_q <= 1'b0; // RL9 RL10
                        tmr_q <= 8'h0;
                        hst_q <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    tmr_q <= tmr_q + 8'h1;
                    if (tmr_q == 8'(RST_WAIT_CYC - 1)) begin
                        link_up_q <= 1'b1; // RL11
                        hst_q <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    tmr_q <= 8'h0;
                    if (~phase_q && rem_q != 4'h0 && req_s && (~dir_load_q || i_wr_valid)) begin
                        adsn_q <= 1'b0;
                        sel1n_q <= 1'b0;
                        sel2_q <= 1'b1;
                        cmdn_q <= 1'b1;
                        wr_q <= dir_load_q;
                        hoe_q <= dir_load_q;
                        hdata_q <= i_wr_data;
                        wr_taken_q <= dir_load_q;
                        hst_q <= H_ADS;
                    end else if (~phase_q && rem_q == 4'h0 && i_cmd_valid && busy_n_s) begin
                        adsn_q <= 1'b0;
                        sel1n_q <= 1'b0;
                        sel2_q <= 1'b1;
                        cmdn_q <= 1'b0;
                        wr_q <= 1'b1;
                        hoe_q <= 1'b1;
                        hdata_q <= {24'h0, i_cmd_op};
                        cmd_taken_q <= 1'b1;
                        dir_load_q <= (i_cmd_op[OP_POS +: 4] == OP_LOAD);
                        if (i_cmd_op[OP_POS +: 4] == OP_LOAD || i_cmd_op[OP_POS +: 4] == OP_STORE) begin
                            rem_q <= i_cmd_op[CNT_POS +: 4];
                        end
                        hst_q <= H_ADS;
                    end
                end
                H_ADS: begin
                    // Strobe low for one internal clock.
                    tmr_q <= tmr_q + 8'h1;
                    if (tmr_q == 8'h1) begin
                        adsn_q <= 1'b1;
                        hst_q <= H_WDONE;
                    end
                end
                H_WDONE: begin
                    if (~done_n_s) begin
                        sel1n_q <= 1'b1;
                        sel2_q <= 1'b0;
                        hoe_q <= 1'b0;
                        if (cmdn_q) begin
                            rem_q <= rem_q - 4'h1;
                            rd_valid_q <= ~wr_q;
                            rd_data_q <= dat_s2_q;
                        end
                        tmr_q <= 8'h0;
                        hst_q <= H_GAP;
                    end
                end
                H_GAP: begin
                    // Lets busy and request settle through the synchronisers.
                    tmr_q <= tmr_q + 8'h1;
                    if (tmr_q == HOST_GAP_CYC) begin
                        hst_q <= H_IDLE;
                    end
                end
                default: hst_q <= H_IDLE;
            endcase
        end
    end

    assign bus.status_enable = 1'b1;
    assign bus.system_reset_in = sreset_q;
    assign bus.address_strobe_n = adsn_q;
    assign bus.select_one_n = sel1n_q;
    assign bus.select_two = sel2_q;
    assign bus.command_select_n = cmdn_q;
    assign bus.write_read = wr_q;
    assign bus.host_data_oe = hoe_q;
    assign bus.host_data_out = hdata_q;
    assign o_cmd_taken = cmd_taken_q;
    assign o_wr_taken = wr_taken_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_data = rd_data_q;
    assign o_link_up = link_up_q;
endmodule : cpx_host
`default_nettype wire

// >>> cpx_link_monitor.sv
// Checker for the coprocessor pin link; watches the device's raw outputs.
// Assumes one host clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module cpx_link_monitor (
    input wire logic i_mclk, // Host clock.
    input wire logic i_rst, // Reset.
    input wire logic status_enable, // Chip enable.
    input wire logic select_one_n, // Select one.
    input wire logic select_two, // Select two.
    input wire logic write_read, // High for write.
    input wire logic address_strobe_n, // Cycle start.
    input wire logic system_reset_in, // Pin reset.
    input wire logic dev_data_oe, // Data drive.
    input wire logic dev_ctl_oe, // Control drive.
    input wire logic cycle_done_n_out, // Ready out.
    input wire logic busy_n_out, // Busy out.
    input wire logic transfer_request_out, // Request out.
    input wire logic error_n_out // Error out.
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire sel = status_enable && !select_one_n && select_two;
    a_data_needs_ctl: assert property (dev_data_oe |-> dev_ctl_oe)
        else $error("data driven while outputs float");
    a_data_on_read: assert property (dev_data_oe |-> $past(sel && !write_read))
        else $error("data driven off a read");
    a_reset_levels: assert property (system_reset_in [*3] |-> busy_n_out && cycle_done_n_out
        && !transfer_request_out && !error_n_out && !dev_data_oe) else $error("wrong levels in reset");
    a_reset_abandon: assert property ($rose(system_reset_in) |-> ##[1:4] busy_n_out && !transfer_request_out)
        else $error("reset not obeyed");
    a_req_before_idle: assert property ($rose(busy_n_out) |-> !$past(transfer_request_out))
        else $error("request after busy");
    a_req_while_busy: assert property (transfer_request_out |-> !busy_n_out)
        else $error("request without busy");
    a_done_selected: assert property (!cycle_done_n_out |-> sel)
        else $error("ready out unselected");
    a_done_two_clk: assert property ($fell(cycle_done_n_out) |=> !cycle_done_n_out ##1 cycle_done_n_out)
        else $error("ready out width");
    a_write_ends: assert property ($fell(address_strobe_n) && sel && write_read |-> ##[2:24] !cycle_done_n_out)
        else $error("write cycle not ended");
    a_read_ends: assert property ($fell(address_strobe_n) && sel && !write_read |-> ##[4:24] !cycle_done_n_out)
        else $error("read cycle not ended");
    c_request: cover property ($rose(transfer_request_out));
    c_read_data: cover property ($rose(dev_data_oe));
    c_error: cover property ($fell(error_n_out) && !system_reset_in);
endmodule : cpx_link_monitor
`default_nettype wire

// >>> cpx_pkg.sv
// Shared constants and types for the coprocessor host handshake.
// Assumes both ends run on one 40 MHz host double-rate clock.
package cpx_pkg;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 16;
    // Bus cycle lengths in internal (divided) clocks.
    localparam logic [1:0] WR_CLKS = 2'h2;
    localparam logic [1:0] RD_CLKS = 2'h3;
    // Core clock may be as slow as 10/16 of the host double clock.
    localparam int CORE_SLOW_NUM = 16;
    localparam int CORE_SLOW_DEN = 10;
    localparam int RST_HOLD_CORE_PERIODS = 40;
    localparam int RST_WAIT_CORE_PERIODS = 50;
    localparam int RST_HOLD_CYC = (RST_HOLD_CORE_PERIODS * CORE_SLOW_NUM + CORE_SLOW_DEN - 1) / CORE_SLOW_DEN;
    localparam int RST_WAIT_CYC = (RST_WAIT_CORE_PERIODS * CORE_SLOW_NUM + CORE_SLOW_DEN - 1) / CORE_SLOW_DEN;
    localparam logic [7:0] EXEC_TICKS = 8'h08;
    localparam logic [7:0] HOST_GAP_CYC = 8'h04;
    // Opcode word layout.
    localparam int OP_POS = 0;
    localparam int CNT_POS = 4;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_LOAD = 4'h1;
    localparam logic [3:0] OP_STORE = 4'h2;
    localparam logic [3:0] OP_CLEAR = 4'h3;
    localparam logic [3:0] OP_FAULT = 4'h4;
    typedef enum logic [1:0] {B_IDLE, B_FOREIGN, B_ACT, B_DONE} cpx_bus_state_type;
    typedef enum logic [2:0] {C_IDLE, C_LOAD, C_EXEC, C_STORE, C_DRAIN, C_END} cpx_core_state_type;
    typedef enum logic [2:0] {H_RST, H_WAIT, H_IDLE, H_ADS, H_WDONE, H_GAP} cpx_host_state_type;
endpackage : cpx_pkg
